//--- rtl/addr_adder.sv
// plain adder for pointers, indexed addresses and branch targets
module addr_adder #(
  parameter int W = 16
) (
  input  wire logic [W-1:0] a_i,
  input  wire logic [W-1:0] b_i,
  output logic      [W-1:0] sum_o
);

  // wraps modulo 2**W, as pointer and pc arithmetic do
  assign sum_o = a_i + b_i;

endmodule : addr_adder

//--- rtl/cmp_exec_pkg.sv
// shared constants and types of the compare/clear execution unit
package cmp_exec_pkg;

  // opcodes handled by the unit
  localparam logic [7:0] OPC_CLR_DIR  = 8'h90;
  localparam logic [7:0] OPC_CLR_IND  = 8'h91;
  localparam logic [7:0] OPC_CP_RR    = 8'h92;
  localparam logic [7:0] OPC_CP_RIR   = 8'h93;
  localparam logic [7:0] OPC_CP_FULL  = 8'h94;
  localparam logic [7:0] OPC_CP_IDST  = 8'hE6;
  localparam logic [7:0] OPC_CP_ISRC  = 8'hE7;
  localparam logic [7:0] OPC_CP_PAIR  = 8'h72;
  localparam logic [7:0] OPC_CP_PINC  = 8'hB4;
  localparam logic [7:0] OPC_CP_PDEC  = 8'hC2;
  localparam logic [7:0] OPC_CP_PIDX  = 8'h60;
  localparam logic [7:0] OPC_CP_IDXR  = 8'h7F;
  localparam logic [7:0] OPC_CP_IDXM  = 8'h26;
  localparam logic [7:0] OPC_CP_ABSR  = 8'hC4;
  localparam logic [7:0] OPC_CP_ABSM  = 8'hC5;
  localparam logic [7:0] OPC_CP_MM    = 8'h73;
  localparam logic [7:0] OPC_CP_IMMR  = 8'h95;
  localparam logic [7:0] OPC_CP_IMMP  = 8'hF3;
  localparam logic [7:0] OPC_CP_IMMA  = 8'h2F;
  localparam logic [7:0] OPC_CP_JUMP  = 8'h9F;

  localparam logic [3:0] OPC_EXT_NIB  = 4'h9;

  // pointer steps and reset values
  localparam logic [15:0] STEP_UP     = 16'h0001;
  localparam logic [15:0] STEP_DOWN   = 16'hFFFF;
  localparam logic [15:0] STEP_NONE   = 16'h0000;
  localparam logic [15:0] ADDR_RST    = 16'h0000;
  localparam logic [7:0]  BYTE_RST    = 8'h00;
  localparam logic [7:0]  ZERO_BYTE   = 8'h00;
  localparam logic [7:0]  NEXT_BYTE   = 8'h01;

  typedef enum logic [2:0] {
    LOC_NONE, LOC_REG, LOC_RIND, LOC_PAIR, LOC_PIDX, LOC_ABS, LOC_IMM
  } loc_type;

  typedef enum logic [1:0] {
    PM_NONE, PM_POSTINC, PM_PREDEC, PM_JUMPINC
  } ptr_mode_type;

  typedef enum logic [4:0] {
    ST_IDLE, ST_OPND, ST_IND, ST_IPTR, ST_REG, ST_PH, ST_PL, ST_PCALC,
    ST_XH, ST_XL, ST_XCALC, ST_MEM, ST_GOT, ST_EXEC, ST_WBH, ST_WBL,
    ST_CLR
  } state_type;

  // ofs holds the offset, the absolute address or the immediate byte
  typedef struct packed {
    loc_type     loc;
    logic [7:0]  raddr;
    logic [7:0]  xaddr;
    logic [15:0] ofs;
  } opnd_type;

  typedef struct packed {
    logic         clear;
    logic         jump;
    logic         jump_true;
    logic         illegal;
    ptr_mode_type pmode;
    logic [7:0]   jofs;
    opnd_type     dst;
    opnd_type     src;
  } plan_type;

  typedef struct packed {
    logic [7:0] opc;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [7:0] b4;
  } instr_type;

  typedef struct packed {
    logic c;
    logic z;
    logic s;
    logic v;
  } flags_type;

  localparam flags_type FLAGS_RST = '0;

endpackage : cmp_exec_pkg

//--- rtl/cmp_flag_unit.sv
// byte subtraction that only yields carry, zero, sign and overflow
module cmp_flag_unit
  import cmp_exec_pkg::*;
(
  input  wire logic [7:0] dst_i,
  input  wire logic [7:0] src_i,
  output flags_type       flags_o
);

  logic [8:0] diff;

  assign diff = {1'b0, dst_i} - {1'b0, src_i};

  always_comb begin
    flags_o.c = diff[8];
    flags_o.z = (diff[7:0] == ZERO_BYTE);
    flags_o.s = diff[7];
    flags_o.v = (dst_i[7] != src_i[7]) && (diff[7] != dst_i[7]);
  end

endmodule : cmp_flag_unit

//--- rtl/compare_clear_exec_unit.sv
// execution unit for clear, byte compare and compare-and-jump
//
// How it works
// - clear writes zero, flags untouched
// - compare sets flags, never writes result
// - carry set on borrow
// - zero flag on zero difference
// - sign flag from difference top bit
// - overflow flag; decimal, half-carry kept
// - register compares, direct and indirect
// - source pair incremented after compare
// - source pair decremented before fetch
// - destination pair incremented after compare
// - destination pair decremented before compare
// - memory source via all addressing modes
// - memory destination via all addressing modes
// - memory to memory through two pairs
// - immediate compare against three destinations
// - jump-if-false branches on nonzero difference
// - jump-if-true branches on zero difference
module compare_clear_exec_unit
  import cmp_exec_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        start_i,
  input  instr_type        instr_i,
  input  wire logic [15:0] next_pc_i,
  input  wire logic [3:0]  wreg_base_i,
  input  wire logic [7:0]  reg_rdata_i,
  input  wire logic [7:0]  mem_rdata_i,
  output logic             busy_o,
  output logic             done_o,
  output logic             illegal_o,
  output logic [7:0]       reg_addr_o,
  output logic             reg_rd_o,
  output logic             reg_wr_o,
  output logic [7:0]       reg_wdata_o,
  output logic [15:0]      mem_addr_o,
  output logic             mem_rd_o,
  output flags_type        flags_o,
  output logic             flags_we_o,
  output logic             pc_load_o,
  output logic [15:0]      pc_target_o
);

  ////////////////////////////////////////////////////////////////////////
  // instruction decode

  function automatic plan_type decode(instr_type in, logic [3:0] wb);
    plan_type   p;
    logic [7:0] w_hi;
    logic [7:0] w_lo;
    logic [7:0] w_b2;
    logic [7:0] pr;
    logic [7:0] pr_hi;
    logic [7:0] rsel;
    p     = '0;
    w_hi  = {wb, in.b1[7:4]};
    w_lo  = {wb, in.b1[3:0]};
    w_b2  = {wb, in.b2[3:0]};
    pr    = {wb, in.b1[3:1], 1'b0};
    pr_hi = {wb, in.b1[7:5], 1'b0};
    rsel  = in.b1[0] ? in.b3 : in.b4;
    case (in.opc)
      OPC_CLR_DIR, OPC_CLR_IND: begin
        p.clear     = 1'b1;
        p.dst.loc   = (in.opc == OPC_CLR_DIR) ? LOC_REG : LOC_RIND;
        p.dst.raddr = in.b1;
      end
      OPC_CP_RR, OPC_CP_RIR: begin
        p.dst.loc   = LOC_REG;
        p.dst.raddr = w_hi;
        p.src.loc   = (in.opc == OPC_CP_RR) ? LOC_REG : LOC_RIND;
        p.src.raddr = w_lo;
      end
      OPC_CP_FULL: begin
        p.src.loc   = LOC_REG;
        p.src.raddr = in.b1;
        p.dst.loc   = LOC_REG;
        p.dst.raddr = in.b2;
      end
      OPC_CP_IDST: begin
        p.illegal   = (in.b2[7:4] != OPC_EXT_NIB);
        p.src.loc   = LOC_REG;
        p.src.raddr = in.b1;
        p.dst.loc   = LOC_RIND;
        p.dst.raddr = w_b2;
      end
      OPC_CP_ISRC: begin
        p.illegal   = (in.b1[7:4] != OPC_EXT_NIB);
        p.src.loc   = LOC_RIND;
        p.src.raddr = w_lo;
        p.dst.loc   = LOC_REG;
        p.dst.raddr = in.b2;
      end
      OPC_CP_PAIR, OPC_CP_PINC, OPC_CP_PDEC: begin
        p.illegal = (in.b1[7:4] != OPC_EXT_NIB);
        p.pmode   = (in.opc == OPC_CP_PINC) ? PM_POSTINC :
                    (in.opc == OPC_CP_PDEC) ? PM_PREDEC : PM_NONE;
        if (in.b1[0]) begin
          p.dst = '{LOC_REG, in.b2, BYTE_RST, ADDR_RST};
          p.src = '{LOC_PAIR, pr, BYTE_RST, ADDR_RST};
        end else begin
          p.dst = '{LOC_PAIR, pr, BYTE_RST, ADDR_RST};
          p.src = '{LOC_REG, in.b2, BYTE_RST, ADDR_RST};
        end
      end
      OPC_CP_PIDX: begin
        p.illegal = (in.b2[7:4] != OPC_EXT_NIB);
        if (in.b1[0]) begin
          p.dst = '{LOC_PIDX, pr, pr_hi, ADDR_RST};
          p.src = '{LOC_REG, w_b2, BYTE_RST, ADDR_RST};
        end else begin
          p.dst = '{LOC_REG, w_b2, BYTE_RST, ADDR_RST};
          p.src = '{LOC_PIDX, pr, pr_hi, ADDR_RST};
        end
      end
      // short offset when the pair low bit is one, long otherwise
      OPC_CP_IDXR, OPC_CP_IDXM: begin
        p.illegal = (in.b1[7:4] != OPC_EXT_NIB);
        if (in.opc == OPC_CP_IDXR) begin
          p.dst.loc   = LOC_REG;
          p.dst.raddr = rsel;
          p.src.loc   = LOC_PAIR;
          p.src.raddr = pr;
          p.src.ofs   = in.b1[0] ? {BYTE_RST, in.b2} : {in.b2, in.b3};
        end else begin
          p.src.loc   = LOC_REG;
          p.src.raddr = rsel;
          p.dst.loc   = LOC_PAIR;
          p.dst.raddr = pr;
          p.dst.ofs   = in.b1[0] ? {BYTE_RST, in.b2} : {in.b2, in.b3};
        end
      end
      OPC_CP_ABSR: begin
        p.illegal = (in.b1[7:4] != OPC_EXT_NIB);
        p.dst     = '{LOC_REG, w_lo, BYTE_RST, ADDR_RST};
        p.src     = '{LOC_ABS, BYTE_RST, BYTE_RST, {in.b2, in.b3}};
      end
      OPC_CP_ABSM: begin
        p.illegal = (in.b1[7:4] != OPC_EXT_NIB);
        p.src     = '{LOC_REG, w_lo, BYTE_RST, ADDR_RST};
        p.dst     = '{LOC_ABS, BYTE_RST, BYTE_RST, {in.b2, in.b3}};
      end
      OPC_CP_MM: begin
        p.illegal = (in.b1[7:4] != OPC_EXT_NIB);
        p.src     = '{LOC_PAIR, pr, BYTE_RST, ADDR_RST};
        p.dst     = '{LOC_PAIR, in.b2, BYTE_RST, ADDR_RST};
      end
      OPC_CP_IMMR: begin
        p.dst = '{LOC_REG, in.b1, BYTE_RST, ADDR_RST};
        p.src = '{LOC_IMM, BYTE_RST, BYTE_RST, {BYTE_RST, in.b2}};
      end
      OPC_CP_IMMP: begin
        p.illegal = (in.b1[7:4] != OPC_EXT_NIB);
        p.dst     = '{LOC_PAIR, pr, BYTE_RST, ADDR_RST};
        p.src     = '{LOC_IMM, BYTE_RST, BYTE_RST, {BYTE_RST, in.b2}};
      end
      OPC_CP_IMMA: begin
        p.dst = '{LOC_ABS, BYTE_RST, BYTE_RST, {in.b1, in.b2}};
        p.src = '{LOC_IMM, BYTE_RST, BYTE_RST, {BYTE_RST, in.b4}};
      end
      OPC_CP_JUMP: begin
        p.jump      = 1'b1;
        p.jump_true = in.b1[4];
        p.pmode     = PM_JUMPINC;
        p.jofs      = in.b2;
        p.dst       = '{LOC_REG, w_lo, BYTE_RST, ADDR_RST};
        p.src       = '{LOC_PAIR, pr_hi, BYTE_RST, ADDR_RST};
      end
      default: begin
        p.illegal = 1'b1;
      end
    endcase
    return p;
  endfunction : decode

  ////////////////////////////////////////////////////////////////////////
  // datapath

  state_type   state_reg;
  plan_type    plan_reg;
  plan_type    plan_new;
  logic        sel_reg;
  logic        from_mem_reg;
  logic [15:0] port_addr_reg;
  logic [7:0]  hi_reg;
  logic [15:0] ptr_reg;
  logic [7:0]  wb_pair_reg;
  logic [7:0]  dst_val_reg;
  logic [7:0]  src_val_reg;
  logic [7:0]  wdata_reg;
  logic [15:0] pc_base_reg;
  opnd_type    cur;
  logic [15:0] ptr_full;
  logic [15:0] step;
  logic [15:0] step_sum;
  logic [15:0] base;
  logic [15:0] ofs_a;
  logic [15:0] ofs_b;
  logic [15:0] ofs_sum;
  logic [15:0] pc_sum;
  logic [7:0]  got_val;
  flags_type   cmp_flags;
  logic        take;
  logic        need_wb;

  assign plan_new = decode(instr_i, wreg_base_i);
  assign cur      = sel_reg ? plan_reg.src : plan_reg.dst;
  assign ptr_full = {hi_reg, reg_rdata_i};
  assign got_val  = from_mem_reg ? mem_rdata_i : reg_rdata_i;

  assign step = (plan_reg.pmode == PM_PREDEC) ? STEP_DOWN :
                (plan_reg.pmode == PM_NONE)   ? STEP_NONE : STEP_UP;
  // predecrement fetches through the already stepped pointer
  assign base  = (plan_reg.pmode == PM_PREDEC) ? step_sum : ptr_full;
  assign ofs_a = (state_reg == ST_XCALC) ? ptr_reg : base;
  assign ofs_b = (state_reg == ST_XCALC) ? ptr_full : cur.ofs;

  addr_adder #(.W(16)) u_step (
    .a_i   (ptr_full),
    .b_i   (step),
    .sum_o (step_sum)
  );

  addr_adder #(.W(16)) u_ofs (
    .a_i   (ofs_a),
    .b_i   (ofs_b),
    .sum_o (ofs_sum)
  );

  addr_adder #(.W(16)) u_pc (
    .a_i   (pc_base_reg),
    .b_i   ({{8{plan_reg.jofs[7]}}, plan_reg.jofs}),
    .sum_o (pc_sum)
  );

  cmp_flag_unit u_cmp (
    .dst_i   (dst_val_reg),
    .src_i   (src_val_reg),
    .flags_o (cmp_flags)
  );

  assign take = plan_reg.jump && (plan_reg.jump_true == cmp_flags.z);

  assign need_wb = (plan_reg.pmode == PM_POSTINC) ||
                   (plan_reg.pmode == PM_PREDEC) ||
                   (plan_reg.pmode == PM_JUMPINC && !take);

  ////////////////////////////////////////////////////////////////////////
  // sequencer

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_IDLE;
      sel_reg   <= 1'b0;
      plan_reg  <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start_i) begin
            plan_reg  <= plan_new;
            sel_reg   <= 1'b0;
            state_reg <= plan_new.illegal ? ST_IDLE : ST_OPND;
          end
        end
        ST_OPND: begin
          case (cur.loc)
            LOC_REG:  state_reg <= plan_reg.clear ? ST_CLR : ST_REG;
            LOC_RIND: state_reg <= ST_IND;
            LOC_PAIR: state_reg <= ST_PH;
            LOC_PIDX: state_reg <= ST_PH;
            LOC_ABS:  state_reg <= ST_MEM;
            default:  state_reg <= ST_EXEC;
          endcase
        end
        ST_IND:   state_reg <= ST_IPTR;
        ST_IPTR:  state_reg <= plan_reg.clear ? ST_CLR : ST_REG;
        ST_REG:   state_reg <= ST_GOT;
        ST_PH:    state_reg <= ST_PL;
        ST_PL:    state_reg <= ST_PCALC;
        ST_PCALC: state_reg <= (cur.loc == LOC_PIDX) ? ST_XH : ST_MEM;
        ST_XH:    state_reg <= ST_XL;
        ST_XL:    state_reg <= ST_XCALC;
        ST_XCALC: state_reg <= ST_MEM;
        ST_MEM:   state_reg <= ST_GOT;
        ST_GOT: begin
          if (!sel_reg && plan_reg.src.loc != LOC_NONE) begin
            sel_reg   <= 1'b1;
            state_reg <= ST_OPND;
          end else begin
            state_reg <= ST_EXEC;
          end
        end
        ST_EXEC:  state_reg <= need_wb ? ST_WBH : ST_IDLE;
        ST_WBH:   state_reg <= ST_WBL;
        default:  state_reg <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // port address, write data and pointer capture

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_addr_reg <= ADDR_RST;
      wdata_reg     <= BYTE_RST;
      hi_reg        <= BYTE_RST;
      ptr_reg       <= ADDR_RST;
      wb_pair_reg   <= BYTE_RST;
      pc_base_reg   <= ADDR_RST;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start_i) begin
            pc_base_reg <= next_pc_i;
          end
        end
        ST_OPND: begin
          port_addr_reg <= (cur.loc == LOC_ABS) ? cur.ofs :
                           {BYTE_RST, cur.raddr};
          wdata_reg     <= ZERO_BYTE;
        end
        ST_IPTR: port_addr_reg <= {BYTE_RST, reg_rdata_i};
        ST_PL, ST_XL: begin
          hi_reg        <= reg_rdata_i;
          port_addr_reg <= {BYTE_RST, port_addr_reg[7:0] + NEXT_BYTE};
        end
        ST_PH, ST_XH: begin
          port_addr_reg <= {BYTE_RST, port_addr_reg[7:0] + NEXT_BYTE};
        end
        ST_PCALC: begin
          ptr_reg       <= step_sum;
          wb_pair_reg   <= cur.raddr;
          port_addr_reg <= (cur.loc == LOC_PIDX) ? {BYTE_RST, cur.xaddr} :
                           ofs_sum;
        end
        ST_XCALC: port_addr_reg <= ofs_sum;
        ST_EXEC: begin
          port_addr_reg <= {BYTE_RST, wb_pair_reg};
          wdata_reg     <= ptr_reg[15:8];
        end
        ST_WBH: begin
          port_addr_reg <= {BYTE_RST, port_addr_reg[7:0] + NEXT_BYTE};
          wdata_reg     <= ptr_reg[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // operand capture

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dst_val_reg  <= BYTE_RST;
      src_val_reg  <= BYTE_RST;
      from_mem_reg <= 1'b0;
    end else begin
      from_mem_reg <= (state_reg == ST_MEM);
      if (state_reg == ST_GOT && !sel_reg) begin
        dst_val_reg <= got_val;
      end
      if (state_reg == ST_GOT && sel_reg) begin
        src_val_reg <= got_val;
      end
      if (state_reg == ST_OPND && cur.loc == LOC_IMM) begin
        src_val_reg <= cur.ofs[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // results: flags, branch and completion

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags_o     <= FLAGS_RST;
      flags_we_o  <= 1'b0;
      pc_load_o   <= 1'b0;
      pc_target_o <= ADDR_RST;
      done_o      <= 1'b0;
      illegal_o   <= 1'b0;
    end else begin
      flags_we_o <= 1'b0;
      pc_load_o  <= 1'b0;
      done_o     <= 1'b0;
      illegal_o  <= 1'b0;
      if (state_reg == ST_IDLE && start_i && plan_new.illegal) begin
        illegal_o <= 1'b1;
        done_o    <= 1'b1;
      end
      if (state_reg == ST_EXEC) begin
        if (!plan_reg.jump) begin
          flags_o    <= cmp_flags;
          flags_we_o <= 1'b1;
        end
        if (take) begin
          pc_load_o   <= 1'b1;
          pc_target_o <= pc_sum;
        end
        done_o <= !need_wb;
      end
      if (state_reg == ST_WBL || state_reg == ST_CLR) begin
        done_o <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // port strobes

  assign busy_o      = (state_reg != ST_IDLE);
  assign reg_addr_o  = port_addr_reg[7:0];
  assign mem_addr_o  = port_addr_reg;
  assign reg_wdata_o = wdata_reg;
  assign mem_rd_o    = (state_reg == ST_MEM);
  assign reg_rd_o    = (state_reg inside {ST_REG, ST_IND, ST_PH, ST_PL,
                                          ST_XH, ST_XL});
  // clear is a write, no flag update
  assign reg_wr_o    = (state_reg inside {ST_CLR, ST_WBH, ST_WBL});

endmodule : compare_clear_exec_unit

//--- verification/cmp_exec_asserts.sv
// concurrent checks on the execution unit's ports
module cmp_exec_asserts
  import cmp_exec_pkg::*;
(
  input wire logic       ref_clk_i,
  input wire logic       rst_n_i,
  input wire logic       start_i,
  input instr_type       instr_i,
  input wire logic [7:0] reg_rdata_i,
  input wire logic       busy_o,
  input wire logic       done_o,
  input wire logic       reg_wr_o,
  input wire logic [7:0] reg_wdata_o,
  input flags_type       flags_o,
  input wire logic       flags_we_o,
  input wire logic       pc_load_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  function automatic logic [7:0] sub8(input logic [7:0] a, b);
    return a - b;
  endfunction : sub8
  function automatic logic ovf8(input logic [7:0] a, b);
    logic [7:0] r;
    r = a - b;
    return (a[7] != b[7]) && (r[7] != a[7]);
  endfunction : ovf8

  sequence s_clr;
    start_i && !busy_o && instr_i.opc == OPC_CLR_DIR;
  endsequence
  sequence s_cp;
    start_i && !busy_o && instr_i.opc == OPC_CP_RR;
  endsequence
  sequence s_jmp;
    start_i && !busy_o && instr_i.opc == OPC_CP_JUMP;
  endsequence
  sequence s_zero_wr;
    reg_wr_o && reg_wdata_o == ZERO_BYTE;
  endsequence

  // operands of a register compare arrive 3 and 6 cycles after start
  a_clear_zero:
    assert property (s_clr |-> ##2 s_zero_wr ##1 (done_o && !flags_we_o))
    else $error("clear did not write zero");
  a_cmp_no_write:
    assert property (s_cp |=> !reg_wr_o [*8])
    else $error("compare wrote a register");
  a_cmp_timing:
    assert property (s_cp |-> ##8 (flags_we_o && done_o))
    else $error("register compare flags late");
  a_carry_borrow:
    assert property (s_cp |-> ##8 (flags_o.c ==
      ($past(reg_rdata_i, 5) < $past(reg_rdata_i, 2))))
    else $error("carry flag wrong");
  a_zero_flag:
    assert property (s_cp |-> ##8 (flags_o.z ==
      (sub8($past(reg_rdata_i, 5), $past(reg_rdata_i, 2)) == ZERO_BYTE)))
    else $error("zero flag wrong");
  a_sign_flag:
    assert property (s_cp |-> ##8 (flags_o.s ==
      (sub8($past(reg_rdata_i, 5), $past(reg_rdata_i, 2)) >= 8'h80)))
    else $error("sign flag wrong");
  a_ovf_flag:
    assert property (s_cp |-> ##8 (flags_o.v ==
      ovf8($past(reg_rdata_i, 5), $past(reg_rdata_i, 2))))
    else $error("overflow flag wrong");
  a_jump_no_flags:
    assert property (s_jmp |=> !flags_we_o [*8] ##1 !flags_we_o [*5])
    else $error("jump loaded flags");
  a_jump_ends:
    assert property (s_jmp |-> ##[6:17] done_o)
    else $error("jump did not finish");
  a_branch_done:
    assert property (pc_load_o |-> done_o && !flags_we_o)
    else $error("branch load outside instruction end");
endmodule : cmp_exec_asserts

bind compare_clear_exec_unit cmp_exec_asserts cmp_exec_asserts_i (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .start_i(start_i),
  .instr_i(instr_i), .reg_rdata_i(reg_rdata_i), .busy_o(busy_o),
  .done_o(done_o), .reg_wr_o(reg_wr_o), .reg_wdata_o(reg_wdata_o),
  .flags_o(flags_o), .flags_we_o(flags_we_o), .pc_load_o(pc_load_o)
);

//--- verification/cmp_exec_partner.sv
// register file and data memory answering the execution unit
module cmp_exec_partner (
  input  wire logic        ref_clk_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_rd_i,
  input  wire logic        reg_wr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic [15:0] mem_addr_i,
  input  wire logic        mem_rd_i,
  output logic      [7:0]  reg_rdata_o,
  output logic      [7:0]  mem_rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] regs [256];
  logic [7:0] mem  [65536];
  initial begin
    reg_rdata_o = 8'h5A;
    mem_rdata_o = 8'hA5;
  end
  // read data stands one cycle; after that the bus toggles so stale
  // values cannot be mistaken for an answer
  always @(posedge ref_clk_i) begin
    reg_rdata_o <= reg_rd_i ? regs[reg_addr_i] : ~reg_rdata_o;
    mem_rdata_o <= mem_rd_i ? mem[mem_addr_i] : ~mem_rdata_o;
    if (reg_wr_i) regs[reg_addr_i] <= reg_wdata_i;
  end
endmodule : cmp_exec_partner

//--- verification/testbench.sv
// self-checking bench for the compare/clear execution unit
module testbench;
  import cmp_exec_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk_i   = 1'b0;
  logic        rst_n_i     = 1'b0;
  logic        start_i     = 1'b0;
  instr_type   instr_i     = '0;
  logic [15:0] next_pc_i   = '0;
  logic [3:0]  wreg_base_i = '0;
  logic [7:0]  reg_rdata, mem_rdata, reg_addr, reg_wdata, a, b, rg, ofs;
  logic [15:0] mem_addr, pc_target, seen_pc, ptr, npc, adr;
  logic        busy, done, illegal, reg_rd, reg_wr, mem_rd, fwe, pc_load;
  logic        tk;
  logic [3:0]  base, r;
  logic [2:0]  p;
  flags_type   flags, seen_f;
  int          err_total = 0;
  int          compares  = 0;
  int          cycles    = 0;
  int          n_fwe, n_pc, n_wr, n_ill, seed;

  compare_clear_exec_unit compare_clear_exec_unit_i (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .start_i(start_i),
    .instr_i(instr_i), .next_pc_i(next_pc_i), .wreg_base_i(wreg_base_i),
    .reg_rdata_i(reg_rdata), .mem_rdata_i(mem_rdata), .busy_o(busy),
    .done_o(done), .illegal_o(illegal), .reg_addr_o(reg_addr),
    .reg_rd_o(reg_rd), .reg_wr_o(reg_wr), .reg_wdata_o(reg_wdata),
    .mem_addr_o(mem_addr), .mem_rd_o(mem_rd), .flags_o(flags),
    .flags_we_o(fwe), .pc_load_o(pc_load), .pc_target_o(pc_target));
  cmp_exec_partner cmp_exec_partner_i (
    .ref_clk_i(ref_clk_i), .reg_addr_i(reg_addr), .reg_rd_i(reg_rd),
    .reg_wr_i(reg_wr), .reg_wdata_i(reg_wdata), .mem_addr_i(mem_addr),
    .mem_rd_i(mem_rd), .reg_rdata_o(reg_rdata), .mem_rdata_o(mem_rdata));

  always #10 ref_clk_i = ~ref_clk_i;

  // pulses are counted per instruction; about 200 cycles per round
  always @(posedge ref_clk_i) begin
    cycles++;
    if (fwe === 1'b1) begin
      n_fwe++;
      seen_f = flags;
    end
    if (pc_load === 1'b1) begin
      n_pc++;
      seen_pc = pc_target;
    end
    if (reg_wr === 1'b1) n_wr++;
    if (illegal === 1'b1) n_ill++;
    if (cycles == 10000) begin
      err_total++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("compares=%0d mismatches=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      err_total++;
    end
  endtask : chk

  function automatic flags_type exp_f(input logic [7:0] d, s);
    logic [7:0] t;
    t = d - s;
    exp_f.c = d < s;
    exp_f.z = t == 8'h00;
    exp_f.s = t[7];
    exp_f.v = (d[7] != s[7]) && (t[7] != d[7]);
  endfunction : exp_f

  task automatic wr(input logic [7:0] ad, input logic [7:0] v);
    cmp_exec_partner_i.regs[ad] = v;
  endtask : wr

  function automatic logic [7:0] rr8(input logic [7:0] ad);
    return cmp_exec_partner_i.regs[ad];
  endfunction : rr8

  task automatic setp(input logic [2:0] q, input logic [15:0] v);
    wr({base, q, 1'b0}, v[15:8]);
    wr({base, q, 1'b1}, v[7:0]);
  endtask : setp

  function automatic logic [15:0] getp(input logic [2:0] q);
    return {rr8({base, q, 1'b0}), rr8({base, q, 1'b1})};
  endfunction : getp

  task automatic run(input instr_type in, input logic [15:0] pc);
    int k;
    @(posedge ref_clk_i);
    start_i   <= 1'b1;
    instr_i   <= in;
    next_pc_i <= pc;
    n_fwe = 0;
    n_pc  = 0;
    n_wr  = 0;
    n_ill = 0;
    // a missing flag load must not pass on an earlier result
    seen_f = 'x;
    @(posedge ref_clk_i);
    start_i <= 1'b0;
    k = 0;
    #1;
    while (done !== 1'b1 && k < 30) begin
      @(posedge ref_clk_i);
      #1;
      k++;
    end
    chk(16'(done), 16'h1);
    @(posedge ref_clk_i);
    #1;
  endtask : run

  ////////////////////////////////////////////////////////////////////////
  initial begin
    seed = $urandom(32'h5064DD72);
    repeat (20) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      base = 4'h8 + 4'($urandom_range(5));
      wreg_base_i <= base;
      a = (i == 1) ? 8'h80 : 8'($urandom);
      b = (i == 0) ? a : 8'($urandom);
      p = 3'($urandom_range(3));
      r = {1'b1, 3'($urandom)};
      rg = {4'h1, r};
      ptr = 16'($urandom);
      npc = 16'($urandom);
      ofs = 8'($urandom);
      wr({base, r}, a);
      wr({base, r ^ 4'h1}, b);
      run({OPC_CP_RR, r, r ^ 4'h1, 24'h0}, 16'h0);
      chk(seen_f, exp_f(a, b));
      chk(16'(n_wr), 16'h0);
      wr(rg, a);
      run({OPC_CP_IMMR, rg, b, 16'h0}, 16'h0);
      chk(seen_f, exp_f(a, b));
      cmp_exec_partner_i.mem[ptr] = a;
      run({OPC_CP_ABSR, 4'h9, r ^ 4'h1, ptr, 8'h0}, 16'h0);
      chk(seen_f, exp_f(b, a));
      run({OPC_CP_ABSM, 4'h9, r ^ 4'h1, ptr, 8'h0}, 16'h0);
      chk(seen_f, exp_f(a, b));
      chk(16'(n_ill), 16'h0);
      for (int k = 0; k < 4; k++) begin
        adr = k[0] ? ptr - 16'h1 : ptr;
        setp(p, ptr);
        cmp_exec_partner_i.mem[adr] = b;
        wr(rg, a);
        run({k[0] ? OPC_CP_PDEC : OPC_CP_PINC, 4'h9, p, k[1], rg, 16'h0},
            16'h0);
        chk(seen_f, k[1] ? exp_f(a, b) : exp_f(b, a));
        chk(getp(p), k[0] ? adr : ptr + 16'h1);
        chk(16'(n_wr), 16'h2);
      end
      cmp_exec_partner_i.mem[ptr] = a;
      setp(p, ptr);
      run({OPC_CP_IMMP, 4'h9, p, 1'b0, b, 16'h0}, 16'h0);
      chk(seen_f, exp_f(a, b));
      run({OPC_CP_IMMA, ptr, 8'h91, b}, 16'h0);
      chk(seen_f, exp_f(a, b));
      setp(p + 3'h4, ptr ^ 16'h8000);
      cmp_exec_partner_i.mem[ptr ^ 16'h8000] = b;
      run({OPC_CP_MM, 4'h9, p, 1'b0, base, p + 3'h4, 1'b0, 16'h0}, 16'h0);
      chk(seen_f, exp_f(b, a));
      chk(16'(n_wr), 16'h0);
      for (int k = 0; k < 4; k++) begin
        setp(p, ptr);
        wr({base, r}, a);
        cmp_exec_partner_i.mem[ptr] = k[1] ? a : ~a;
        tk = k[0] == k[1];
        run({OPC_CP_JUMP, p, k[0], r, ofs, 16'h0}, npc);
        chk(16'(n_pc), 16'(tk));
        if (tk) chk(seen_pc, npc + {{8{ofs[7]}}, ofs});
        chk(getp(p), tk ? ptr : ptr + 16'h1);
        chk(16'(n_fwe), 16'h0);
      end
      wr(rg, a | 8'h01);
      run({OPC_CLR_DIR, rg, 24'h0}, 16'h0);
      chk(rr8(rg), 8'h00);
      wr(rg, {4'h2, r});
      wr({4'h2, r}, 8'hFF);
      run({OPC_CLR_IND, rg, 24'h0}, 16'h0);
      chk(rr8({4'h2, r}), 8'h00);
      chk(16'(n_fwe), 16'h0);
      run({OPC_CP_MM, 4'h3, p, 1'b0, 24'h0}, 16'h0);
      chk(16'(n_ill), 16'h1);
      $display("test %0d done", i);
    end
    stop_test();
  end
endmodule : testbench
